/* File: logic/sbwc_standby_wakeup_control.sv */
package sbwc_pkg;

  typedef enum logic [1:0] {
    SBWC_RUN,
    SBWC_STANDBY,
    SBWC_WARMUP
  } sbwc_state_type;

  typedef struct packed {
    logic osc;   // Oscillator running
    logic wdt;   // Watchdog clocked
    logic chip;  // Rest of chip clocked
  } sbwc_clk_gate_type;

  localparam int unsigned SBWC_WDT_CNT_W = 10;
  localparam int unsigned SBWC_WDT_SEL_W = 3;
  // Log2 of the warm-up length in cycles, per clock select code
  localparam logic [3:0] SBWC_WDT_SHIFT [8] = '{
    4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9
  };
  localparam sbwc_clk_gate_type SBWC_GATE_RESET = '{osc: 1'h1, wdt: 1'h1, chip: 1'h1};

endpackage

module sbwc_standby_wakeup_control
  import sbwc_pkg::*;
(
  input  wire logic                      ref_clk_in,                // 100 MHz reference
  input  wire logic                      rst_b_in,                  // Reset pin, active low
  input  wire logic                      manual_reset_in,           // Manual reset request
  input  wire logic                      nmi_pin_in,                // Interrupt pin level
  input  wire logic                      nmi_edge_select_in,        // 1 rising, 0 falling
  input  wire logic                      standby_bit_in,            // Standby bit of control reg
  input  wire logic                      sleep_exec_in,             // Sleep instruction pulse
  input  wire logic [SBWC_WDT_SEL_W-1:0] watchdog_clock_select_in,  // Warm-up length code
  output sbwc_clk_gate_type              clk_gate_out,              // Clock gating enables
  output logic                           standby_out,               // In standby or warm-up
  output logic                           wdt_overflow_out,          // Clock-stable pulse
  output logic                           nmi_exception_out,         // Exception start pulse
  output logic                           nmi_accept_out             // Interrupt accepted pulse
);

  sbwc_state_type                state_q;
  sbwc_state_type                state_d;
  logic [SBWC_WDT_CNT_W-1:0]     wdt_cnt_q;
  sbwc_clk_gate_type             gate_q;
  logic                          standby_q;
  logic                          ovf_q;
  logic                          exc_q;
  logic                          accept_q;
  logic                          nmi_edge;
  logic                          wdt_ovf;

  function automatic logic [SBWC_WDT_CNT_W-1:0] sbwc_wdt_limit(
    input logic [SBWC_WDT_SEL_W-1:0] sel);
    sbwc_wdt_limit = SBWC_WDT_CNT_W'((1 << SBWC_WDT_SHIFT[sel]) - 1);
  endfunction

  sbwc_edge_detect u_edge (
    .ref_clk_in  (ref_clk_in),
    .rst_b_in    (rst_b_in),
    .pin_in      (nmi_pin_in),
    .rise_sel_in (nmi_edge_select_in),
    .edge_out    (nmi_edge)
  );

  assign wdt_ovf = (state_q == SBWC_WARMUP) &&
                   (wdt_cnt_q == sbwc_wdt_limit(watchdog_clock_select_in));

  always_comb begin
    state_d = state_q;
    case (state_q)
      SBWC_RUN: begin
        if (sleep_exec_in && standby_bit_in && !manual_reset_in) begin
          state_d = SBWC_STANDBY;
        end
      end
      SBWC_STANDBY: begin
        if (manual_reset_in) begin
          state_d = SBWC_RUN;
        end else if (nmi_edge) begin
          state_d = SBWC_WARMUP;
        end
      end
      SBWC_WARMUP: begin
        if (manual_reset_in || wdt_ovf) begin
          state_d = SBWC_RUN;
        end
      end
      default: begin
        state_d = SBWC_RUN;
      end
    endcase
  end

  // Power-on reset cancels standby whatever the watchdog is doing
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= SBWC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Watchdog counts only while it alone is clocked
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wdt_cnt_q <= '0;
    end else if (state_d == SBWC_WARMUP && state_q == SBWC_WARMUP) begin
      wdt_cnt_q <= wdt_cnt_q + SBWC_WDT_CNT_W'(1);
    end else begin
      wdt_cnt_q <= '0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gate_q <= SBWC_GATE_RESET;
    end else begin
      gate_q.osc  <= (state_d != SBWC_STANDBY);
      gate_q.wdt  <= (state_d != SBWC_STANDBY);
      gate_q.chip <= (state_d == SBWC_RUN);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      standby_q <= 1'h0;
    end else begin
      standby_q <= (state_d != SBWC_RUN);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ovf_q <= 1'h0;
      exc_q <= 1'h0;
    end else begin
      ovf_q <= wdt_ovf;
      exc_q <= wdt_ovf && !manual_reset_in;
    end
  end

  // Normal acceptance while running
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      accept_q <= 1'h0;
    end else begin
      accept_q <= nmi_edge && (state_q == SBWC_RUN);
    end
  end

  assign clk_gate_out      = gate_q;
  assign standby_out       = standby_q;
  assign wdt_overflow_out  = ovf_q;
  assign nmi_exception_out = exc_q;
  assign nmi_accept_out    = accept_q;

  a_sleep_enters_standby: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (state_q == SBWC_RUN && sleep_exec_in && standby_bit_in && !manual_reset_in)
    |=> (standby_out && !clk_gate_out.chip && !clk_gate_out.osc))
    else $error("sleep with standby bit did not stop clock");

  a_exit_has_cause: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    $fell(standby_out) |-> ($past(manual_reset_in) || $past(wdt_ovf)))
    else $error("standby left without a valid cause");

  a_wake_restarts_osc: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (state_q == SBWC_STANDBY && nmi_edge && !manual_reset_in)
    |=> (clk_gate_out.osc && clk_gate_out.wdt && !clk_gate_out.chip))
    else $error("edge in standby did not restart oscillator");

  a_warmup_wdt_only: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (state_q == SBWC_WARMUP) |-> (clk_gate_out.wdt && !clk_gate_out.chip))
    else $error("chip clocked during warm-up");

  a_wdt_min_period: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ($rose(state_q == SBWC_WARMUP) && watchdog_clock_select_in == 3'h0)
    ##0 (!manual_reset_in && watchdog_clock_select_in == 3'h0) [*4]
    |=> (clk_gate_out.chip && nmi_exception_out))
    else $error("warm-up length wrong for select 0");

  a_overflow_releases: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (wdt_ovf && !manual_reset_in)
    |=> (clk_gate_out.chip && !standby_out && nmi_exception_out && wdt_overflow_out))
    else $error("overflow did not release chip");

  a_reset_cancels: assert property (@(posedge ref_clk_in)
    (!$past(rst_b_in) && rst_b_in) |-> (!standby_out && clk_gate_out.chip))
    else $error("reset did not cancel standby");

  a_fall_accept: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (state_q == SBWC_RUN && !nmi_edge_select_in && $fell(nmi_pin_in))
    |-> ##2 (nmi_accept_out || $past(state_q) != SBWC_RUN))
    else $error("falling edge not accepted");

  a_rise_accept: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (state_q == SBWC_RUN && nmi_edge_select_in && $rose(nmi_pin_in))
    |-> ##2 (nmi_accept_out || $past(state_q) != SBWC_RUN))
    else $error("rising edge not accepted");

  c_standby_entry: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    $rose(state_q == SBWC_STANDBY));

  c_nmi_wakeup: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    nmi_exception_out);

  c_manual_exit: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (state_q != SBWC_RUN && manual_reset_in));

endmodule // sbwc_standby_wakeup_control

/* File: logic/sbwc_edge_detect.sv */
module sbwc_edge_detect (
  input  wire logic ref_clk_in,   // Always-on reference clock
  input  wire logic rst_b_in,     // Async reset, active low
  input  wire logic pin_in,       // Interrupt pin level
  input  wire logic rise_sel_in,  // 1 selects rising edge, 0 falling
  output logic      edge_out      // One-cycle pulse on selected edge
);

  logic prev_q;
  logic edge_q;

  function automatic logic sbwc_sel_edge(input logic prev, input logic cur, input logic rise);
    sbwc_sel_edge = rise ? (~prev & cur) : (prev & ~cur);
  endfunction

  // Runs on the reference clock, which keeps going while the chip clock is gated
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_q <= 1'h0;
    end else begin
      prev_q <= pin_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      edge_q <= 1'h0;
    end else begin
      edge_q <= sbwc_sel_edge(prev_q, pin_in, rise_sel_in);
    end
  end

  assign edge_out = edge_q;

  a_edge_rise_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (rise_sel_in && $rose(pin_in)) |=> edge_out)
    else $error("rising edge not flagged");

  a_edge_fall_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (!rise_sel_in && $fell(pin_in)) |=> edge_out)
    else $error("falling edge not flagged");

endmodule // sbwc_edge_detect

/* File: dv/sbwc_ext_system.sv */
module sbwc_ext_system (
  input  wire logic ref_clk_in,   // Reference clock
  output logic      nmi_pin_out,  // Interrupt pin level
  output logic      rst_b_out     // Reset pin, active low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    nmi_pin_out = 1'h1;
    rst_b_out = 1'h0;
  end
  // Inactive level before standby entry
  task automatic idle(input logic rise);
    @(posedge ref_clk_in);
    nmi_pin_out <= ~rise;
  endtask
  // Active level, held through the restart
  task automatic fire(input logic rise, output time t);
    @(posedge ref_clk_in);
    nmi_pin_out <= rise;
    t = $time;
  endtask
  task automatic set_reset(input logic lvl, output time t);
    @(posedge ref_clk_in);
    rst_b_out <= lvl;
    t = $time;
  endtask
endmodule  // sbwc_ext_system

/* File: dv/tb.sv */
module tb;
  import sbwc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [63:0] t; logic [6:0] v;} sbwc_note_type;
  logic              ref_clk_in = 1'h0;
  logic              rst_b_in;
  logic              nmi_pin_in;
  logic              manual_reset_in = 1'h0;
  logic              nmi_edge_select_in = 1'h0;
  logic              standby_bit_in = 1'h0;
  logic              sleep_exec_in = 1'h0;
  logic [2:0]        watchdog_clock_select_in = 3'h0;
  sbwc_clk_gate_type clk_gate_out;
  logic              standby_out;
  logic              wdt_overflow_out;
  logic              nmi_exception_out;
  logic              nmi_accept_out;
  logic [6:0]        prev = 7'h70;
  logic [6:0]        snap;
  sbwc_note_type     note;
  sbwc_note_type     notes[$];
  int                err_count = 0;
  int                check_count = 0;
  time               t0;
  int unsigned       k;

  always #5 ref_clk_in = ~ref_clk_in;

  sbwc_ext_system i_sbwc_ext_system (.ref_clk_in(ref_clk_in), .nmi_pin_out(nmi_pin_in),
    .rst_b_out(rst_b_in));
  sbwc_standby_wakeup_control i_sbwc_standby_wakeup_control (.ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in), .manual_reset_in(manual_reset_in), .nmi_pin_in(nmi_pin_in),
    .nmi_edge_select_in(nmi_edge_select_in), .standby_bit_in(standby_bit_in),
    .sleep_exec_in(sleep_exec_in), .watchdog_clock_select_in(watchdog_clock_select_in),
    .clk_gate_out(clk_gate_out), .standby_out(standby_out),
    .wdt_overflow_out(wdt_overflow_out), .nmi_exception_out(nmi_exception_out),
    .nmi_accept_out(nmi_accept_out));

  task automatic expect_at(input time t, input logic [6:0] v);
    notes.push_back('{t: 64'(t), v: v});
  endtask
  task automatic cmp_val(input logic [6:0] got, input logic [6:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_time(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sleep(input logic b, output time t);
    @(posedge ref_clk_in);
    standby_bit_in <= b;
    sleep_exec_in <= 1'h1;
    t = $time;
    @(posedge ref_clk_in);
    sleep_exec_in <= 1'h0;
  endtask
  task automatic wrap_up();
    if (notes.size() != 0) err_count++;
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Any pulse or level change must match the oldest note
  always @(negedge ref_clk_in) begin
    snap = {clk_gate_out, standby_out, wdt_overflow_out, nmi_exception_out, nmi_accept_out};
    if (snap[2:0] !== 3'h0 || snap[6:3] !== prev[6:3]) begin
      if (notes.size() == 0) begin
        cmp_val(snap, {prev[6:3], 3'h0});
      end else begin
        note = notes.pop_front();
        cmp_time(64'($time), note.t);
        cmp_val(snap, note.v);
      end
    end
    prev = snap;
  end

  initial begin
    #50000;
    err_count++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h6cd5));
    repeat (2) @(posedge ref_clk_in);
    i_sbwc_ext_system.set_reset(1'h1, t0);
    for (int s = 0; s < 2; s++) begin
      nmi_edge_select_in <= s[0];
      i_sbwc_ext_system.idle(s[0]);
      repeat (3) @(posedge ref_clk_in);
      i_sbwc_ext_system.fire(s[0], t0);
      expect_at(t0 + 25, 7'h71);
      repeat (4) @(posedge ref_clk_in);
    end
    nmi_edge_select_in <= 1'h0;
    i_sbwc_ext_system.idle(1'h0);
    sleep(1'h0, t0);
    sleep(1'h1, t0);
    expect_at(t0 + 15, 7'h08);
    repeat (3) @(posedge ref_clk_in);
    manual_reset_in <= 1'h1;
    expect_at($time + 15, 7'h70);
    @(posedge ref_clk_in);
    manual_reset_in <= 1'h0;
    for (int s = 0; s < 2; s++) begin
      k = (s == 0) ? 32'h0 : $urandom_range(3, 1);
      watchdog_clock_select_in <= k[2:0];
      nmi_edge_select_in <= s[0];
      i_sbwc_ext_system.idle(s[0]);
      sleep(1'h1, t0);
      expect_at(t0 + 15, 7'h08);
      repeat ($urandom_range(7)) @(posedge ref_clk_in);
      i_sbwc_ext_system.fire(s[0], t0);
      expect_at(t0 + 25, 7'h68);
      expect_at(t0 + 15 + (1 + (1 << (k + 2))) * 10, 7'h76);
      repeat ((1 << (k + 2)) + 6) @(posedge ref_clk_in);
    end
    // Manual reset cuts a warm-up short, with no exception
    nmi_edge_select_in <= 1'h0;
    i_sbwc_ext_system.idle(1'h0);
    sleep(1'h1, t0);
    expect_at(t0 + 15, 7'h08);
    i_sbwc_ext_system.fire(1'h0, t0);
    expect_at(t0 + 25, 7'h68);
    repeat (3) @(posedge ref_clk_in);
    manual_reset_in <= 1'h1;
    expect_at($time + 15, 7'h70);
    @(posedge ref_clk_in);
    manual_reset_in <= 1'h0;
    nmi_edge_select_in <= 1'h0;
    i_sbwc_ext_system.idle(1'h0);
    sleep(1'h1, t0);
    expect_at(t0 + 15, 7'h08);
    repeat (2) @(posedge ref_clk_in);
    i_sbwc_ext_system.set_reset(1'h0, t0);
    expect_at(t0 + 5, 7'h70);
    repeat (3) @(posedge ref_clk_in);
    i_sbwc_ext_system.set_reset(1'h1, t0);
    repeat (2) @(posedge ref_clk_in);
    i_sbwc_ext_system.fire(1'h0, t0);
    expect_at(t0 + 25, 7'h71);
    repeat (10) @(posedge ref_clk_in);
    wrap_up();
  end
endmodule  // tb
